// ---- dcirq_pkg.sv ----
// Purpose: Shared constants and types for the dual-core interrupt and event router
// Assumes: Peripheral lines and core signals are synchronous to clk
// Notes:   APB register map uses byte addresses, one 32-bit word per register
package dcirq_pkg;
	// Sizes
	localparam int NumCores  = 2;
	localparam int NumIrq    = 32;
	localparam int NumSys    = 26;
	localparam int PrioBits  = 2;
	localparam int PrioField = 8;
	localparam int LvlW      = 3;
	localparam logic [LvlW-1:0] LvlNone = 3'h4;
	// Register map
	localparam logic [11:0] AddrCoreBase = 12'h000;
	localparam logic [11:0] CoreStride   = 12'h010;
	localparam logic [3:0]  OffNmiSel    = 4'h0;
	localparam logic [3:0]  OffEnable    = 4'h4;
	localparam logic [3:0]  OffSetPend   = 4'h8;
	localparam logic [3:0]  OffActive    = 4'hc;
	localparam logic [11:0] AddrStatus   = 12'h020;
	localparam logic [11:0] AddrMask     = 12'h024;
	localparam logic [5:0]  PrioRegion   = 6'h01;
	// Status bits: NMI rise per core, event latched per core, chip sleep entry
	localparam int StNmiBase = 0;
	localparam int StEvBase  = 2;
	localparam int StSleep   = 4;
	localparam int StatusW   = 5;
	// Peripheral interrupt sources shared by both cores
	typedef struct packed {
		logic       rtc;
		logic [1:0] i2c;
		logic       adcFifo;
		logic [1:0] uart;
		logic [1:0] spi;
		logic       clocks;
		logic [1:0] coreFifo;
		logic       qspiBank;
		logic [1:0] dma;
		logic [1:0] progIo1;
		logic [1:0] progIo0;
		logic       execInPlace;
		logic       usbController;
		logic       pwmWrap;
		logic [3:0] timer;
	} dcirq_periph_type;
	// Core to router
	typedef struct packed {
		logic sendEvent;
		logic eventConsume;
		logic irqTake;
		logic irqDone;
		logic faultEnter;
		logic faultExit;
		logic sleeping;
	} dcirq_core_req_type;
	// Router to core
	typedef struct packed {
		logic       irqReq;
		logic [4:0] irqNum;
		logic       nmi;
		logic       eventFlag;
		logic       eventPulse;
	} dcirq_core_rsp_type;
endpackage

// ---- dcirq_router.sv ----
// Purpose: Interrupt routing, per-core priority nesting, NMI forming and event cross-wiring
// Assumes: All inputs share clk; cores give one-cycle take/done/fault/consume pulses
// Notes:   APB slave answers with zero wait states
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Each core has own 32-input interrupt controller
// - Shared lines, GPIO bank line per core
// - Inputs 26 to 31 tied low
// - Software set-pending enters handler for all
// - Lines 0-12: timers, PWM, USB, XIP, PIO, DMA
// - Lines 13-25: GPIO, QSPI, FIFO, clocks, serial, RTC
// - Higher priority preempts; lower resumes after
// - Two-bit priority in 8-bit field, 0 first
// - Equal level: lower number wins
// - Per core AND lines with mask, OR
// - Own NMI mask per core, one bit each
// - Each core's send-event wakes the other
// - Event flag sticky until consumed
// - Gate fabric clock when both cores sleep and DMA is idle
module dcirq_router (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset,
	// APB slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [11:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Interrupt sources
	input  wire dcirq_pkg::dcirq_periph_type  periph,
	input  wire logic [1:0]                   gpioBankZeroLine,
	// Cores
	input  wire dcirq_pkg::dcirq_core_req_type coreReq [dcirq_pkg::NumCores],
	output dcirq_pkg::dcirq_core_rsp_type     coreRsp [dcirq_pkg::NumCores],
	// Chip sleep
	input  wire logic                         dmaBusy,
	output logic                              fabricClkEn,
	// Block interrupt
	output logic                              irq
);
	import dcirq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [NumSys-1:0]   nmiSel_q   [NumCores];
	logic [NumIrq-1:0]   enable_q   [NumCores];
	logic [NumIrq-1:0]   softPend_q [NumCores];
	logic [PrioBits-1:0] prio_q     [NumCores][NumIrq];
	logic [NumIrq-1:0]   lines      [NumCores];
	logic [NumIrq-1:0]   pend       [NumCores];
	logic [NumIrq-1:0]   pendView   [NumCores];
	logic [31:0]         activeWord [NumCores];
	logic [3:0]          active_q   [NumCores];
	logic                fault_q    [NumCores];
	logic                req_q      [NumCores];
	logic [4:0]          num_q      [NumCores];
	logic [LvlW-1:0]     lvl_q      [NumCores];
	logic                nmi_q      [NumCores];
	logic                sev_q      [NumCores];
	logic                evPulse_q  [NumCores];
	logic                evFlag_q   [NumCores];
	logic [StatusW-1:0]  status_q;
	logic [StatusW-1:0]  status_d;
	logic [StatusW-1:0]  mask_q;
	logic [StatusW-1:0]  statusSet;
	logic                asleep_q;
	logic                fabricClkEn_q;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	// Transfer qualifiers
	wire        access   = psel & penable;
	wire        wrEn     = access & pwrite;

	// Per-core window, one 16-byte block per core
	wire        inCore   = (paddr[11:5] == AddrCoreBase[11:5]);
	wire        coreSel  = paddr[4];
	wire [3:0]  coreOff  = paddr[3:0];

	// Block status and mask words
	wire        hitStat  = (paddr == AddrStatus);
	wire        hitMask  = (paddr == AddrMask);

	// Priority words, one 32-byte block per core
	wire        hitPrio  = (paddr[11:6] == PrioRegion) && (paddr[1:0] == 2'b00);
	wire        prioCore = paddr[5];
	wire [2:0]  prioWord = paddr[4:2];

	// Any decoded word; misaligned addresses never hit
	wire        hitCore  = inCore && (coreOff[1:0] == 2'b00);
	wire        mapped   = hitCore | hitStat | hitMask | hitPrio;

	// Zero wait states; error only on unmapped words
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// Read mux; unmapped reads return zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (hitCore) begin
			case (coreOff)
				OffNmiSel:  prdata = {{(32-NumSys){1'b0}}, nmiSel_q[coreSel]};
				OffEnable:  prdata = enable_q[coreSel];
				OffSetPend: prdata = pendView[coreSel];
				OffActive:  prdata = activeWord[coreSel];
				default:    prdata = 32'h0000_0000;
			endcase
		end else if (hitStat) begin
			prdata = {{(32-StatusW){1'b0}}, status_q};
		end else if (hitMask) begin
			prdata = {{(32-StatusW){1'b0}}, mask_q};
		end else if (hitPrio) begin
			// Each byte holds one priority in its top two bits
			for (int b = 0; b < 4; b++) begin
				prdata[b*PrioField +: PrioField] =
					{prio_q[prioCore][{prioWord, 2'(b)}], {(PrioField-PrioBits){1'b0}}};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-core routing, selection and nesting
	for (genvar c = 0; c < NumCores; c++) begin : g_core
		localparam int Other = NumCores - 1 - c;
		logic            found;
		logic [4:0]      bestNum;
		logic [LvlW-1:0] bestLvl;
		logic [LvlW-1:0] runLvl;
		logic            preempt;
		logic            nmi_d;
		logic [3:0]      active_d;
		logic [3:0]      lvlBit;

		wire wrThis = wrEn & hitCore & (coreSel == 1'(c));

		// Core accepted the registered request this cycle
		wire taken = coreReq[c].irqTake & req_q[c];

		// Bits set by a set-pending write and cleared by a take
		wire [NumIrq-1:0] pendSet = (wrThis && coreOff == OffSetPend) ? pwdata : '0;
		wire [NumIrq-1:0] pendClr = taken ? (32'h0000_0001 << num_q[c]) : '0;

		// shared lines, bank line per core
		assign lines[c] = {{(NumIrq-NumSys){1'b0}}, periph.rtc, periph.i2c, periph.adcFifo,
			periph.uart, periph.spi, periph.clocks, periph.coreFifo, periph.qspiBank,
			gpioBankZeroLine[c], periph.dma, periph.progIo1, periph.progIo0,
			periph.execInPlace, periph.usbController, periph.pwmWrap, periph.timer};

		assign pend[c] = (lines[c] | softPend_q[c]) & enable_q[c];

		// Unenabled pending view for set-pending reads
		assign pendView[c] = softPend_q[c] | lines[c];

		// Active word: level, number, request, level set, fault
		assign activeWord[c] = {18'h0_0000, fault_q[c], active_q[c], req_q[c],
			num_q[c], lvl_q[c]};

		////////////////////////////////////////////////////////////////////////////
		// Priority selection and nesting
		// scan high to low so lower number wins ties
		always_comb begin
			found   = 1'b0;
			bestNum = 5'h00;
			bestLvl = LvlNone;
			for (int i = NumIrq - 1; i >= 0; i--) begin
				if (pend[c][i] && ({1'b0, prio_q[c][i]} <= bestLvl)) begin
					found   = 1'b1;
					bestNum = 5'(i);
					bestLvl = {1'b0, prio_q[c][i]};
				end
			end
		end

		// Running level is the most urgent active level
		always_comb begin
			runLvl = LvlNone;
			for (int l = 3; l >= 0; l--) begin
				if (active_q[c][l]) begin
					runLvl = 3'(l);
				end
			end
		end

		// preempt only on strictly more urgent level, never over a fault
		assign preempt = found && !fault_q[c] && (bestLvl < runLvl);

		// take stacks the level, done pops the most urgent one
		assign lvlBit = 4'b0001 << lvl_q[c][1:0];
		always_comb begin
			active_d = active_q[c];
			if (coreReq[c].irqDone) begin
				active_d = active_d & ~(4'b0001 << runLvl[1:0]);
			end
			if (taken) begin
				active_d = active_d | lvlBit;
			end
		end

		// AND lines with mask then OR
		assign nmi_d = |(lines[c][NumSys-1:0] & nmiSel_q[c]);

		// Request, number and level registers
		always_ff @(posedge clk) begin
			if (reset) begin
				req_q[c] <= 1'b0;
				num_q[c] <= 5'h00;
				lvl_q[c] <= LvlNone;
			end else begin
				req_q[c] <= preempt && !taken;
				num_q[c] <= bestNum;
				lvl_q[c] <= bestLvl;
			end
		end

		// Nesting stack and fault state
		always_ff @(posedge clk) begin
			if (reset) begin
				active_q[c] <= 4'h0;
				fault_q[c]  <= 1'b0;
			end else begin
				active_q[c] <= active_d;
				fault_q[c]  <= (fault_q[c] & ~coreReq[c].faultExit) | coreReq[c].faultEnter;
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// Software-visible registers of this core
		// set-pending write sets, taking clears; set wins
		always_ff @(posedge clk) begin
			if (reset) begin
				softPend_q[c] <= '0;
			end else begin
				softPend_q[c] <= (softPend_q[c] & ~pendClr) | pendSet;
			end
		end

		// Software configuration per core
		always_ff @(posedge clk) begin
			if (reset) begin
				nmiSel_q[c] <= '0;
				enable_q[c] <= '0;
			end else begin
				if (wrThis && coreOff == OffNmiSel) nmiSel_q[c] <= pwdata[NumSys-1:0];
				if (wrThis && coreOff == OffEnable) enable_q[c] <= pwdata;
			end
		end

		// only top two bits of each byte are kept
		for (genvar i = 0; i < NumIrq; i++) begin : g_prio
			always_ff @(posedge clk) begin
				if (reset) begin
					prio_q[c][i] <= '0;
				end else if (wrEn && hitPrio && prioCore == 1'(c) && prioWord == 3'(i / 4)) begin
					prio_q[c][i] <= pwdata[(i % 4)*PrioField + PrioField - PrioBits +: PrioBits];
				end
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// Event cross-wiring between the cores
		// other core's send-event drives this core
		// rising edge gives one delivery pulse
		// latch holds until consumed; set wins
		always_ff @(posedge clk) begin
			if (reset) begin
				nmi_q[c]     <= 1'b0;
				sev_q[c]     <= 1'b0;
				evPulse_q[c] <= 1'b0;
				evFlag_q[c]  <= 1'b0;
			end else begin
				nmi_q[c]     <= nmi_d;
				sev_q[c]     <= coreReq[c].sendEvent;
				evPulse_q[c] <= coreReq[Other].sendEvent & ~sev_q[Other];
				evFlag_q[c]  <= (evFlag_q[c] & ~coreReq[c].eventConsume) | evPulse_q[c];
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// Outputs towards the core and the status block
		// Core-facing outputs
		assign coreRsp[c].irqReq     = req_q[c];
		assign coreRsp[c].irqNum     = num_q[c];
		assign coreRsp[c].nmi        = nmi_q[c];
		assign coreRsp[c].eventFlag  = evFlag_q[c];
		assign coreRsp[c].eventPulse = evPulse_q[c];

		// Status events for this core
		assign statusSet[StNmiBase + c] = nmi_d & ~nmi_q[c];
		assign statusSet[StEvBase + c]  = evPulse_q[c];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Chip sleep
	wire allAsleep = coreReq[0].sleeping & coreReq[1].sleeping & ~dmaBusy;

	// gate while all idle, restore as soon as one wakes
	always_ff @(posedge clk) begin
		if (reset) begin
			asleep_q      <= 1'b0;
			fabricClkEn_q <= 1'b1;
		end else begin
			asleep_q      <= allAsleep;
			fabricClkEn_q <= ~allAsleep;
		end
	end
	assign fabricClkEn        = fabricClkEn_q;
	assign statusSet[StSleep] = allAsleep & ~asleep_q;

	////////////////////////////////////////////////////////////////////////////////
	// Block status, write one to clear, set wins
	// Bits that this access asks to clear
	wire [StatusW-1:0] statusClr = (wrEn && hitStat) ? pwdata[StatusW-1:0] : '0;
	assign status_d = (status_q & ~statusClr) | statusSet;

	always_ff @(posedge clk) begin
		if (reset) begin
			status_q <= '0;
			mask_q   <= '0;
		end else begin
			status_q <= status_d;
			if (wrEn && hitMask) mask_q <= pwdata[StatusW-1:0];
		end
	end

	// Level interrupt while any unmasked status bit is set
	assign irq = |(status_q & mask_q);

endmodule // dcirq_router

`default_nettype wire

// ---- dcirq_router_sva.sv ----
// Purpose: Port-level checks for the interrupt and event router
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every router instance
`timescale 1ns/1ps
`default_nettype none
module dcirq_router_sva
	import dcirq_pkg::*;
(
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	// Watched ports
	input  wire dcirq_pkg::dcirq_periph_type   periph,
	input  wire logic [1:0]                    gpioBankZeroLine,
	input  wire dcirq_pkg::dcirq_core_req_type coreReq [dcirq_pkg::NumCores],
	input  wire dcirq_pkg::dcirq_core_rsp_type coreRsp [dcirq_pkg::NumCores],
	input  wire logic                          dmaBusy,
	input  wire logic                          fabricClkEn
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_nmiOff;
		(periph == '0 && gpioBankZeroLine == 2'h0) |=> !coreRsp[0].nmi && !coreRsp[1].nmi;
	endproperty
	a_nmiOff: assert property (p_nmiOff) else $error("NMI without a line");
	property p_cross;
		$rose(coreReq[0].sendEvent) |=> coreRsp[1].eventPulse;
	endproperty
	a_cross: assert property (p_cross) else $error("Event not passed across");
	property p_pulse;
		coreRsp[1].eventPulse |=> !coreRsp[1].eventPulse;
	endproperty
	a_pulse: assert property (p_pulse) else $error("Event pulse too long");
	property p_flag;
		coreRsp[1].eventPulse |=> coreRsp[1].eventFlag;
	endproperty
	a_flag: assert property (p_flag) else $error("Event flag not set");
	property p_sticky;
		coreRsp[0].eventFlag && !coreReq[0].eventConsume |=> coreRsp[0].eventFlag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("Event flag lost");
	property p_sleep;
		coreReq[0].sleeping && coreReq[1].sleeping && !dmaBusy |=> !fabricClkEn;
	endproperty
	a_sleep: assert property (p_sleep) else $error("Fabric clock not gated");
	property p_wake;
		!coreReq[0].sleeping || !coreReq[1].sleeping || dmaBusy |=> fabricClkEn;
	endproperty
	a_wake: assert property (p_wake) else $error("Fabric clock not restored");
	property p_take;
		coreReq[0].irqTake && coreRsp[0].irqReq |=> !coreRsp[0].irqReq;
	endproperty
	a_take: assert property (p_take) else $error("Request kept after take");
endmodule // dcirq_router_sva
bind dcirq_router dcirq_router_sva dcirq_router_sva_inst (.clk(clk), .reset(reset),
	.periph(periph), .gpioBankZeroLine(gpioBankZeroLine), .coreReq(coreReq),
	.coreRsp(coreRsp), .dmaBusy(dmaBusy), .fabricClkEn(fabricClkEn));
`default_nettype wire

// ---- dcirq_core_model.sv ----
// Purpose: Behavioural processor core facing the router
// Assumes: Handlers run for hold cycles, nested on a stack
// Notes:   Take delay is random, 0 to 3 cycles
`timescale 1ns/1ps
`default_nettype none
module dcirq_core_model (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	// Router side
	input  wire dcirq_pkg::dcirq_core_rsp_type rsp,
	output dcirq_pkg::dcirq_core_req_type      req,
	// Bench controls
	input  wire logic                          send_event_instr,
	input  wire logic                          slp,
	input  wire logic                          wait_for_event_instr,
	input  wire logic [7:0]                    hold
);
	import dcirq_pkg::*;
	int stk[$];
	int dly;
	dcirq_core_req_type nxt;
	// One decision per clock, one update of req; only the innermost handler runs
	always @(posedge clk) begin
		nxt = '0;
		nxt.sendEvent = send_event_instr;
		nxt.sleeping = slp;
		nxt.eventConsume = wait_for_event_instr && rsp.eventFlag && !req.eventConsume;
		if (reset) begin
			stk.delete();
			dly = 0;
		end else if (stk.size() > 0 && stk[$] == 0) begin
			nxt.irqDone = 1'b1;
			void'(stk.pop_back());
		end else begin
			if (stk.size() > 0) stk[$] = stk[$] - 1;
			if (rsp.irqReq === 1'b1 && !req.irqTake) begin
				if (dly > 0) dly--;
				else begin
					nxt.irqTake = 1'b1;
					stk.push_back(int'(hold));
					dly = $urandom_range(3, 0);
				end
			end
		end
		req <= nxt;
	end
endmodule // dcirq_core_model
`default_nettype wire

// ---- dcirq_router_tb.sv ----
// Purpose: Self-checking bench for the interrupt and event router
// Assumes: Zero-wait APB slave, cores modelled behaviourally
// Notes:   Read results and core 0 taken interrupt numbers are checked from queues
`timescale 1ns/1ps
`default_nettype none
module dcirq_router_tb;
	import dcirq_pkg::*;
	logic               clk, reset, psel, penable, pwrite, pready, pslverr, irq;
	logic               dmaBusy, fabricClkEn, irqE;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata;
	logic [1:0]         gpio, send_event_instr, slp, wait_for_event_instr;
	logic [7:0]         hold;
	dcirq_periph_type   periph;
	dcirq_core_req_type coreReq [NumCores];
	dcirq_core_rsp_type coreRsp [NumCores];
	int                 failures, comparisons;
	logic [33:0]        qBus[$];
	logic [4:0]         qIrq[$];
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	dcirq_router dcirq_router_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph(periph), .gpioBankZeroLine(gpio), .coreReq(coreReq),
		.coreRsp(coreRsp), .dmaBusy(dmaBusy), .fabricClkEn(fabricClkEn), .irq(irq));
	for (genvar c = 0; c < NumCores; c++) begin : g_core
		dcirq_core_model dcirq_core_model_inst (.clk(clk), .reset(reset), .rsp(coreRsp[c]),
			.req(coreReq[c]), .send_event_instr(send_event_instr[c]), .slp(slp[c]), .wait_for_event_instr(wait_for_event_instr[c]), .hold(hold));
	end
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic e, input logic [31:0] d);
		qBus.push_back({irqE, e, d});
		xfer(1'b0, a, 32'h0000_0000);
	endtask
	task automatic drain(input int lim);
		int n;
		n = 0;
		while (qIrq.size() != 0 && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(34'(qIrq.size()), 34'h0);
	endtask
	task automatic end_of_test();
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Result watcher: read data with irq, and core 0 taken interrupt numbers
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) chk({irq, pslverr, prdata}, qBus.pop_front());
		if (coreReq[0].irqTake && coreRsp[0].irqReq) begin
			chk(34'(coreRsp[0].irqNum), 34'(qIrq.pop_front()));
		end
	end
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{periph, gpio, send_event_instr, slp, wait_for_event_instr, dmaBusy, irqE, hold} = '0;
		void'($urandom(32'hbe4240ee));
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(12'h000, 1'b0, 32'h0000_0000);
		rd(12'h00c, 1'b0, 32'h0000_0004);
		rd(12'h030, 1'b1, 32'h0000_0000);
		rd(12'h002, 1'b1, 32'h0000_0000);
		$display("Test reset done");
		xfer(1'b1, 12'h000, 32'h0000_0020);
		xfer(1'b1, 12'h010, 32'h0040_2000);
		periph <= dcirq_periph_type'(25'(($urandom & 32'h00df_ffff) | 32'h0000_0020));
		gpio <= 2'h1;
		repeat (3) @(posedge clk);
		rd(12'h020, 1'b0, 32'h0000_0001);
		xfer(1'b1, 12'h024, 32'h0000_0001);
		irqE = 1'b1;
		rd(12'h024, 1'b0, 32'h0000_0001);
		xfer(1'b1, 12'h020, 32'h0000_001f);
		irqE = 1'b0;
		rd(12'h020, 1'b0, 32'h0000_0000);
		periph <= '0;
		gpio <= 2'h0;
		xfer(1'b1, 12'h024, 32'h0000_0000);
		$display("Test nmi done");
		xfer(1'b1, 12'h060, 32'hffff_ffff);
		rd(12'h060, 1'b0, 32'hc0c0_c0c0);
		xfer(1'b1, 12'h040, 32'h4000_0000);
		xfer(1'b1, 12'h004, 32'hffff_ffff);
		hold <= 8'h08;
		qIrq = '{5'd5, 5'd27, 5'd3};
		xfer(1'b1, 12'h008, 32'h0800_0028);
		drain(500);
		$display("Test priority done");
		hold <= 8'h3c;
		repeat (12) @(posedge clk);
		qIrq = '{5'd3};
		xfer(1'b1, 12'h008, 32'h0000_0008);
		drain(500);
		qIrq = '{5'd30};
		xfer(1'b1, 12'h008, 32'h4000_0000);
		drain(10);
		rd(12'h00c, 1'b0, 32'h0000_0604);
		$display("Test nesting done");
		xfer(1'b1, 12'h020, 32'h0000_001f);
		send_event_instr <= 2'h1;
		@(posedge clk) send_event_instr <= 2'h0;
		repeat (3) @(posedge clk);
		rd(12'h020, 1'b0, 32'h0000_0008);
		xfer(1'b1, 12'h020, 32'h0000_001f);
		send_event_instr <= 2'h3;
		@(posedge clk) send_event_instr <= 2'h0;
		repeat (3) @(posedge clk);
		rd(12'h020, 1'b0, 32'h0000_000c);
		chk(34'({coreRsp[0].eventFlag, coreRsp[1].eventFlag}), 34'h3);
		wait_for_event_instr <= 2'h3;
		repeat (4) @(posedge clk);
		chk(34'({coreRsp[0].eventFlag, coreRsp[1].eventFlag}), 34'h0);
		$display("Test events done");
		xfer(1'b1, 12'h020, 32'h0000_001f);
		dmaBusy <= 1'b1;
		slp <= 2'h3;
		repeat (4) @(posedge clk);
		rd(12'h020, 1'b0, 32'h0000_0000);
		chk(34'(fabricClkEn), 34'h1);
		dmaBusy <= 1'b0;
		repeat (4) @(posedge clk);
		rd(12'h020, 1'b0, 32'h0000_0010);
		chk(34'(fabricClkEn), 34'h0);
		slp <= 2'h1;
		repeat (4) @(posedge clk);
		chk(34'(fabricClkEn), 34'h1);
		$display("Test sleep done");
		xfer(1'b1, 12'h010, 32'h0000_2000);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		gpio <= 2'h2;
		repeat (3) @(posedge clk);
		rd(12'h010, 1'b0, 32'h0000_0000);
		rd(12'h020, 1'b0, 32'h0000_0000);
		$display("Test reset again done");
		end_of_test();
	end
endmodule // dcirq_router_tb
`default_nettype wire
